/* src/keypad_editor_defines.vh */
/*
 * Constants for the keypad parameter editor: register offsets, field
 * positions, reset values, access levels, display codes and timing.
 * Assumes a 125 MHz clock; all long times are counted in 1 ms ticks.
 */
`ifndef KEYPAD_EDITOR_DEFINES_VH
`define KEYPAD_EDITOR_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 8
`define TICK_NS 1000000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define DEBOUNCE_MS 20
`define LONG_PRESS_MS 2000
`define TIMEOUT_MS 60000
`define MESSAGE_MS 1000
`define BLINK_MS 500
`define HOUR_MS 3600000

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CODE_WORD 8'h08
`define OFS_ACC_WR 8'h0c
`define OFS_VAL_SEL 8'h10
`define OFS_VAL_DATA 8'h14
`define OFS_BATT_CAP 8'h18
`define OFS_DATE_NOW 8'h1c
`define OFS_BCHG_DATE 8'h20
`define OFS_OP_HOURS 8'h24
`define OFS_EVENT_CNT 8'h28
`define OFS_COORD 8'h2c

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_CUSTODY 0
`define CTRL_ECO 1
`define ACC_IDX_LSB 8
`define CTRL_RST 2'h0
`define BATT_FULL 7'h64
`define BATT_WARN 7'h0a
`define CODE_MAX 32'h00000004

// ****************************************
// Access levels
// ****************************************
`define ACC_N 2'h0
`define ACC_A 2'h1
`define ACC_C 2'h2
`define ACC_E 2'h3

// ****************************************
// Special coordinates, index = {column, row}
// ****************************************
`define CODE_WORD_ENTRY_COORD 6'h3f
`define BATTERY_CHANGE_COORD 6'h2d
`define CURRENT_OUTPUT_MODE_COORD 6'h20
`define OUTPUT2_PULSE_WIDTH_COORD 6'h05

// Fixed pulse widths, digit-packed.
`define PW_20 32'h00000020
`define PW_125 32'h00000125
`define PW_250 32'h00000250

// ****************************************
// Display modes and archive event codes
// ****************************************
`define DM_METER 3'h0
`define DM_VALUE 3'h1
`define DM_COORD 3'h2
`define DM_EDIT 3'h3
`define DM_GOOD 3'h4
`define DM_RANGE 3'h5
`define EV_CODE_ON 2'h1
`define EV_CODE_OFF 2'h2
`define EV_CAL_OPEN 2'h3

`endif

/* src/key_filter.v */
/*
 * One debounced key: press pulse, short-release pulse and long-hold pulse.
 * Assumes the raw key is synchronous to clk and active high.
 */
`timescale 1ns/10ps

module key_filter #(
	parameter DEB_TK = 20,
	parameter LONG_TK = 2000
) (
	input wire clk,
	input wire rstn,
	input wire tick,
	input wire raw,
	output reg press_reg,
	output reg short_reg,
	output reg long_reg
);

reg level_reg;
reg long_done_reg;
reg [7:0] deb_reg;
reg [15:0] hold_reg;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		level_reg <= 1'b0;
		long_done_reg <= 1'b0;
		deb_reg <= 8'h00;
		hold_reg <= 16'h0000;
		press_reg <= 1'b0;
		short_reg <= 1'b0;
		long_reg <= 1'b0;
	end else begin
		press_reg <= 1'b0;
		short_reg <= 1'b0;
		long_reg <= 1'b0;
		if (level_reg && tick && !long_done_reg) begin
			if (hold_reg >= LONG_TK - 1) begin
				long_reg <= 1'b1;
				long_done_reg <= 1'b1;
			end else begin
				hold_reg <= hold_reg + 16'h0001;
			end
		end
		if (raw == level_reg) begin
			deb_reg <= 8'h00;
		end else if (tick) begin
			// A level counts only after it stood for the whole filter time.
			if (deb_reg >= DEB_TK - 1) begin
				level_reg <= raw;
				deb_reg <= 8'h00;
				hold_reg <= 16'h0000;
				long_done_reg <= 1'b0;
				press_reg <= raw;
				short_reg <= ~raw & ~long_done_reg;
			end else begin
				deb_reg <= deb_reg + 8'h01;
			end
		end
	end
end

endmodule // key_filter

/* src/keypad_editor.v */
/*
 * Front-panel keypad controller: navigation over the coordinate table,
 * digit editing, access gating, timeouts, blanking and battery bookkeeping,
 * with a classic Wishbone slave for the registers.
 * Assumes keys and calibration button are synchronous, active high.
 */
// Function
// - Short OK shows coordinate, OK held over 2 s enters edit mode.
// - Left and right arrows step the column by one.
// - Up/down move rows while navigating, change the blinking digit while editing.
// - One minute without keys returns the display to the main meter.
// - Energy saving blanks the display fully; measuring continues elsewhere.
// - Any key press while blanked restores the display.
// - Each coordinate has an access level; display-only refuses, no-password accepts.
// - Code-word parameters change only after the right code word was entered.
// - Calibration level needs the button on custody variant, else the code word.
// - Code word on/off and calibration opening each log an archive event.
// - Open calibration access shows a blinking input indicator.
// - Digit sequence includes -1 after 0 for negative values.
// - Moving in front of the top digit adds one more digit.
// - Holding right puts the decimal point after the blinking digit.
// - Holding left aborts the entry and discards edits.
// - Short OK confirms; plausibility check runs and shows at once.
// - Implausible shows range message and keeps old; plausible shows good, stores.
// - Calibration access closes on a second press or a minute after opening or the last confirmed entry.
// - Non-numeric settings are numeric codes; current mode takes 0 to 4.
// - Fixed-value settings step through their literals; pulse width 20/125/250 ms.
// - Battery change entry updates date, clears hours, sets capacity to 100 %.
// - Battery change keeps all counters and counting parameters.
// - Warn when remaining battery capacity is below 10 %.
`timescale 1ns/10ps
`include "keypad_editor_defines.vh"

module keypad_editor #(
	parameter TICK_CYC = `TICK_CYC,
	parameter DEB_TK = `DEBOUNCE_MS,
	parameter LONG_TK = `LONG_PRESS_MS,
	parameter MIN_TK = `TIMEOUT_MS,
	parameter MSG_TK = `MESSAGE_MS,
	parameter BLINK_TK = `BLINK_MS,
	parameter HOUR_TK = `HOUR_MS
) (
	input wire clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire wb_ack_o,
	output wire [31:0] wb_dat_o,
	input wire key_up,
	input wire key_down,
	input wire key_left,
	input wire key_right,
	input wire key_ok,
	input wire cal_button,
	output wire [2:0] disp_mode,
	output wire disp_blank,
	output wire [2:0] cur_col,
	output wire [2:0] cur_row,
	output wire [31:0] edit_digits,
	output wire [2:0] edit_cursor,
	output wire [2:0] edit_dp,
	output wire [3:0] edit_ndig,
	output wire digit_blink,
	output wire input_ind,
	output wire batt_warn,
	output wire event_stb,
	output wire [1:0] event_code
);

localparam ST_NAV = 2'h0;
localparam ST_EDIT = 2'h1;
localparam ST_MSG = 2'h2;

// ****************************************
// Tick and keys
// ****************************************
reg [16:0] tick_cnt_reg;
reg tick_reg;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		tick_cnt_reg <= 17'h00000;
		tick_reg <= 1'b0;
	end else if (tick_cnt_reg >= TICK_CYC - 1) begin
		tick_cnt_reg <= 17'h00000;
		tick_reg <= 1'b1;
	end else begin
		tick_cnt_reg <= tick_cnt_reg + 17'h00001;
		tick_reg <= 1'b0;
	end
end

wire [5:0] raw_keys = {cal_button, key_ok, key_right, key_left, key_down, key_up};
wire [5:0] kp;
wire [5:0] ks;
wire [5:0] kl;

genvar gi;
generate
	for (gi = 0; gi < 6; gi = gi + 1) begin : g_key
		key_filter #(.DEB_TK(DEB_TK), .LONG_TK(LONG_TK)) u_key (
			.clk(clk),
			.rstn(rstn),
			.tick(tick_reg),
			.raw(raw_keys[gi]),
			.press_reg(kp[gi]),
			.short_reg(ks[gi]),
			.long_reg(kl[gi])
		);
	end
endgenerate

wire any_key = |kp[4:0];

// ****************************************
// Registers and memories
// ****************************************
reg [1:0] ctrl_reg;
reg [31:0] code_word_reg;
reg [5:0] val_sel_reg;
reg [6:0] batt_cap_reg;
reg [31:0] date_now_reg;
reg [31:0] bchg_date_reg;
reg [15:0] op_hours_reg;
reg [21:0] hour_tk_reg;
reg [15:0] event_cnt_reg;
reg ack_reg;
reg [31:0] dat_reg;
reg [31:0] val_mem [0:63];
reg [2:0] dp_mem [0:63];
reg [1:0] acc_mem [0:63];

reg [1:0] st_reg;
reg [2:0] mode_reg;
reg blank_reg;
reg [2:0] col_reg;
reg [2:0] row_reg;
reg [31:0] buf_reg;
reg [2:0] curs_reg;
reg [2:0] dp_reg;
reg [3:0] ndig_reg;
reg code_ok_reg;
reg cal_open_reg;
reg [17:0] idle_reg;
reg [16:0] cal_tk_reg;
reg [9:0] msg_tk_reg;
reg [8:0] blink_tk_reg;
reg blink_reg;
reg input_ind_reg;
reg batt_warn_reg;
reg ev_stb_reg;
reg [1:0] ev_code_reg;
reg store_reg;
reg [5:0] store_idx_reg;
reg bchg_reg;

wire [5:0] idx = {col_reg, row_reg};
wire [1:0] acc = acc_mem[idx];
wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
wire bus_wr = bus_req & wb_we_i;
wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
wire [31:0] wdat = wb_dat_i & wmask;
wire [3:0] dig = buf_reg[{curs_reg, 2'b00} +: 4];

// Access gate for the selected coordinate.
reg can_wr;
always @* begin
	case (acc)
	`ACC_N: can_wr = 1'b1;
	`ACC_C: can_wr = code_ok_reg;
	`ACC_E: can_wr = ctrl_reg[`CTRL_CUSTODY] ? cal_open_reg : code_ok_reg;
	default: can_wr = 1'b0;
	endcase
end

// A -1 digit is only a sign, so it may stand only in the top digit.
reg plausible;
integer i;
always @* begin
	plausible = 1'b1;
	for (i = 0; i < 8; i = i + 1) begin
		if (buf_reg[i*4 +: 4] == 4'hf && i != ndig_reg - 1) begin
			plausible = 1'b0;
		end
	end
	if (idx == `CURRENT_OUTPUT_MODE_COORD && buf_reg > `CODE_MAX) begin
		plausible = 1'b0;
	end
end

// Number of digits shown when editing starts: up to the top non-zero one.
reg [3:0] top_dig;
integer j;
always @* begin
	top_dig = 4'h1;
	for (j = 0; j < 8; j = j + 1) begin
		if (val_mem[idx][j*4 +: 4] != 4'h0) begin
			top_dig = j[3:0] + 4'h1;
		end
	end
end

// ****************************************
// Navigation and editing
// ****************************************
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		st_reg <= ST_NAV;
		mode_reg <= `DM_METER;
		blank_reg <= 1'b0;
		col_reg <= 3'h0;
		row_reg <= 3'h0;
		buf_reg <= 32'h00000000;
		curs_reg <= 3'h0;
		dp_reg <= 3'h0;
		ndig_reg <= 4'h1;
		code_ok_reg <= 1'b0;
		cal_open_reg <= 1'b0;
		idle_reg <= 18'h00000;
		cal_tk_reg <= 17'h00000;
		msg_tk_reg <= 10'h000;
		blink_tk_reg <= 9'h000;
		blink_reg <= 1'b0;
		input_ind_reg <= 1'b0;
		ev_stb_reg <= 1'b0;
		ev_code_reg <= 2'h0;
		store_reg <= 1'b0;
		store_idx_reg <= 6'h00;
		bchg_reg <= 1'b0;
	end else begin
		ev_stb_reg <= 1'b0;
		store_reg <= 1'b0;
		bchg_reg <= 1'b0;
		if (tick_reg) begin
			if (blink_tk_reg >= BLINK_TK - 1) begin
				blink_tk_reg <= 9'h000;
				blink_reg <= ~blink_reg;
			end else begin
				blink_tk_reg <= blink_tk_reg + 9'h001;
			end
			if (idle_reg < 2 * MIN_TK) begin
				idle_reg <= idle_reg + 18'h00001;
			end
			cal_tk_reg <= cal_tk_reg + 17'h00001;
			msg_tk_reg <= msg_tk_reg + 10'h001;
		end
		input_ind_reg <= cal_open_reg & blink_reg;
		if (any_key) begin
			idle_reg <= 18'h00000;
		end
		if (kp[5]) begin
			cal_open_reg <= ~cal_open_reg;
			cal_tk_reg <= 17'h00000;
			if (!cal_open_reg) begin
				ev_stb_reg <= 1'b1;
				ev_code_reg <= `EV_CAL_OPEN;
			end
		end else if (cal_open_reg && tick_reg && cal_tk_reg >= MIN_TK - 1) begin
			cal_open_reg <= 1'b0;
		end
		if (blank_reg) begin
			// The waking press only restores the display; a later short release or hold of OK still acts in navigation.
			if (any_key) begin
				blank_reg <= 1'b0;
				mode_reg <= `DM_VALUE;
			end
		end else begin
			case (st_reg)
			ST_NAV: begin
				if (kp[0]) begin
					row_reg <= row_reg - 3'h1;
				end
				if (kp[1]) begin
					row_reg <= row_reg + 3'h1;
				end
				if (kp[2]) begin
					col_reg <= col_reg - 3'h1;
				end
				if (kp[3]) begin
					col_reg <= col_reg + 3'h1;
				end
				if (|kp[3:0]) begin
					mode_reg <= `DM_VALUE;
				end
				if (ks[4]) begin
					mode_reg <= `DM_COORD;
				end
				if (kl[4] && can_wr) begin
					st_reg <= ST_EDIT;
					mode_reg <= `DM_EDIT;
					buf_reg <= val_mem[idx];
					dp_reg <= dp_mem[idx];
					ndig_reg <= top_dig;
					curs_reg <= 3'h0;
				end
			end
			ST_EDIT: begin
				if (idx == `OUTPUT2_PULSE_WIDTH_COORD) begin
					if (kp[0]) begin
						buf_reg <= (buf_reg == `PW_20) ? `PW_125 : `PW_250;
					end
					if (kp[1]) begin
						buf_reg <= (buf_reg == `PW_250) ? `PW_125 : `PW_20;
					end
				end else begin
					if (kp[0] && dig != 4'h9) begin
						buf_reg[{curs_reg, 2'b00} +: 4] <= (dig == 4'hf) ? 4'h0 : dig + 4'h1;
					end
					if (kp[1] && dig != 4'hf) begin
						buf_reg[{curs_reg, 2'b00} +: 4] <= (dig == 4'h0) ? 4'hf : dig - 4'h1;
					end
					if (ks[2] && curs_reg != 3'h7) begin
						curs_reg <= curs_reg + 3'h1;
						if ({1'b0, curs_reg} == ndig_reg - 4'h1) begin
							ndig_reg <= ndig_reg + 4'h1;
						end
					end
					if (ks[3] && curs_reg != 3'h0) begin
						curs_reg <= curs_reg - 3'h1;
					end
					if (kl[3]) begin
						dp_reg <= curs_reg;
					end
				end
				if (kl[2]) begin
					st_reg <= ST_NAV;
					mode_reg <= `DM_VALUE;
				end else if (ks[4]) begin
					st_reg <= ST_MSG;
					msg_tk_reg <= 10'h000;
					cal_tk_reg <= 17'h00000;
					if (idx == `CODE_WORD_ENTRY_COORD) begin
						// The code word is compared, never kept in the table.
						mode_reg <= (buf_reg == code_word_reg) ? `DM_GOOD : `DM_RANGE;
						if ((buf_reg == code_word_reg) != code_ok_reg) begin
							code_ok_reg <= ~code_ok_reg;
							ev_stb_reg <= 1'b1;
							ev_code_reg <= code_ok_reg ? `EV_CODE_OFF : `EV_CODE_ON;
						end
					end else if (plausible) begin
						mode_reg <= `DM_GOOD;
						store_reg <= 1'b1;
						store_idx_reg <= idx;
						bchg_reg <= (idx == `BATTERY_CHANGE_COORD);
					end else begin
						mode_reg <= `DM_RANGE;
					end
				end
			end
			ST_MSG: begin
				if (tick_reg && msg_tk_reg >= MSG_TK - 1) begin
					st_reg <= ST_NAV;
					mode_reg <= `DM_VALUE;
				end
			end
			default: begin
				st_reg <= ST_NAV;
			end
			endcase
			if (tick_reg && st_reg != ST_MSG && idle_reg == MIN_TK - 1) begin
				st_reg <= ST_NAV;
				mode_reg <= `DM_METER;
			end
			if (tick_reg && ctrl_reg[`CTRL_ECO] && idle_reg == 2 * MIN_TK - 1) begin
				blank_reg <= 1'b1;
			end
		end
	end
end

// Table writes: a confirmed entry wins over a bus write in the same cycle.
always @(posedge clk) begin
	if (store_reg) begin
		val_mem[store_idx_reg] <= buf_reg;
		dp_mem[store_idx_reg] <= dp_reg;
	end else if (bus_wr && wb_adr_i == `OFS_VAL_DATA) begin
		val_mem[val_sel_reg] <= wdat;
	end
	if (bus_wr && wb_adr_i == `OFS_ACC_WR && wb_sel_i[1] && wb_sel_i[0]) begin
		acc_mem[wb_dat_i[`ACC_IDX_LSB +: 6]] <= wb_dat_i[1:0];
	end
end

// ****************************************
// Wishbone slave and battery bookkeeping
// ****************************************
reg [31:0] rd_data;
always @* begin
	case (wb_adr_i)
	`OFS_CTRL: rd_data = {30'h00000000, ctrl_reg};
	`OFS_STATUS: rd_data = {22'h000000, ndig_reg, batt_warn_reg, blank_reg,
		cal_open_reg, code_ok_reg, st_reg};
	`OFS_CODE_WORD: rd_data = code_word_reg;
	`OFS_VAL_SEL: rd_data = {26'h0000000, val_sel_reg};
	`OFS_VAL_DATA: rd_data = val_mem[val_sel_reg];
	`OFS_BATT_CAP: rd_data = {25'h0000000, batt_cap_reg};
	`OFS_DATE_NOW: rd_data = date_now_reg;
	`OFS_BCHG_DATE: rd_data = bchg_date_reg;
	`OFS_OP_HOURS: rd_data = {16'h0000, op_hours_reg};
	`OFS_EVENT_CNT: rd_data = {16'h0000, event_cnt_reg};
	`OFS_COORD: rd_data = {26'h0000000, idx};
	default: rd_data = 32'h00000000;
	endcase
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		ack_reg <= 1'b0;
		dat_reg <= 32'h00000000;
		ctrl_reg <= `CTRL_RST;
		code_word_reg <= 32'h00000000;
		val_sel_reg <= 6'h00;
		batt_cap_reg <= `BATT_FULL;
		date_now_reg <= 32'h00000000;
		bchg_date_reg <= 32'h00000000;
		op_hours_reg <= 16'h0000;
		hour_tk_reg <= 22'h000000;
		event_cnt_reg <= 16'h0000;
		batt_warn_reg <= 1'b0;
	end else begin
		ack_reg <= bus_req;
		if (bus_req) begin
			dat_reg <= rd_data;
		end
		if (bus_wr) begin
			case (wb_adr_i)
			`OFS_CTRL: ctrl_reg <= (ctrl_reg & ~wmask[1:0]) | wdat[1:0];
			`OFS_CODE_WORD: code_word_reg <= (code_word_reg & ~wmask) | wdat;
			`OFS_VAL_SEL: val_sel_reg <= (val_sel_reg & ~wmask[5:0]) | wdat[5:0];
			`OFS_DATE_NOW: date_now_reg <= (date_now_reg & ~wmask) | wdat;
			default: begin
			end
			endcase
		end
		if (ev_stb_reg) begin
			event_cnt_reg <= event_cnt_reg + 16'h0001;
		end
		if (tick_reg) begin
			if (hour_tk_reg >= HOUR_TK - 1) begin
				hour_tk_reg <= 22'h000000;
				op_hours_reg <= op_hours_reg + 16'h0001;
			end else begin
				hour_tk_reg <= hour_tk_reg + 22'h000001;
			end
		end
		// Only date, hours and capacity change; counters stay untouched.
		if (bchg_reg) begin
			bchg_date_reg <= date_now_reg;
			op_hours_reg <= 16'h0000;
			hour_tk_reg <= 22'h000000;
			batt_cap_reg <= `BATT_FULL;
		end else if (bus_wr && wb_adr_i == `OFS_BATT_CAP) begin
			batt_cap_reg <= (batt_cap_reg & ~wmask[6:0]) | wdat[6:0];
		end
		batt_warn_reg <= (batt_cap_reg < `BATT_WARN);
	end
end

assign wb_ack_o = ack_reg;
assign wb_dat_o = dat_reg;
assign disp_mode = mode_reg;
assign disp_blank = blank_reg;
assign cur_col = col_reg;
assign cur_row = row_reg;
assign edit_digits = buf_reg;
assign edit_cursor = curs_reg;
assign edit_dp = dp_reg;
assign edit_ndig = ndig_reg;
assign digit_blink = blink_reg;
assign input_ind = input_ind_reg;
assign batt_warn = batt_warn_reg;
assign event_stb = ev_stb_reg;
assign event_code = ev_code_reg;

endmodule // keypad_editor

/* testbench/keypad_operator.sv */
/*
 * Keypad operator: holds one key or the calibration button for a commanded
 * number of cycles, then releases all keys for a gap so the release settles.
 * Assumes the bench pulses go for one cycle while busy is low.
 */
`timescale 1ns/10ps

module keypad_operator #(
	parameter GAP = 60
) (
	input wire clk,
	input wire rstn,
	input wire go,
	input wire [2:0] key_sel,
	input wire [15:0] hold_cyc,
	output wire key_up,
	output wire key_down,
	output wire key_left,
	output wire key_right,
	output wire key_ok,
	output wire cal_button,
	output wire busy
);
	reg [5:0] keys_reg;
	reg [15:0] cnt_reg;
	reg [1:0] phase_reg;

	// Keys never bounce here, so any refused press points at the design.
	assign {cal_button, key_ok, key_right, key_left, key_down, key_up} = keys_reg;
	assign busy = (phase_reg != 2'h0);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			keys_reg <= 6'h00;
			cnt_reg <= 16'h0000;
			phase_reg <= 2'h0;
		end else if (phase_reg == 2'h0) begin
			if (go) begin
				keys_reg <= 6'h01 << key_sel;
				cnt_reg <= hold_cyc;
				phase_reg <= 2'h1;
			end
		end else if (cnt_reg != 16'h0000) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end else if (phase_reg == 2'h1) begin
			keys_reg <= 6'h00;
			cnt_reg <= 16'(GAP);
			phase_reg <= 2'h2;
		end else begin
			phase_reg <= 2'h0;
		end
	end
endmodule // keypad_operator

/* testbench/keypad_editor_sva.sv */
/*
 * Concurrent checks on the ports of the keypad editor.
 * Assumes one clock domain and the bench's shortened timing parameters.
 */
`timescale 1ns/10ps
`include "keypad_editor_defines.vh"

module keypad_editor_sva #(
	parameter TICK_CYC = 10,
	parameter DEB_TK = 2,
	parameter MIN_TK = 100
) (
	input wire clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire key_up,
	input wire key_down,
	input wire key_left,
	input wire key_right,
	input wire key_ok,
	input wire cal_button,
	input wire [2:0] disp_mode,
	input wire disp_blank,
	input wire [2:0] cur_col,
	input wire [2:0] edit_cursor,
	input wire [3:0] edit_ndig,
	input wire digit_blink,
	input wire input_ind,
	input wire event_stb,
	input wire [1:0] event_code
);
	// ****************************************
	// Idle counter and properties
	// ****************************************
	// Margin covers the release debounce and the tick phase.
	localparam int IDLE_LIM = (MIN_TK + 4 * DEB_TK + 4) * TICK_CYC;
	int idle_reg;
	wire any_key = key_up | key_down | key_left | key_right | key_ok | cal_button;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			idle_reg <= 0;
		else if (any_key)
			idle_reg <= 0;
		else if (idle_reg < IDLE_LIM)
			idle_reg <= idle_reg + 1;
	end

	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	edit_entry_a: assert property ($rose(disp_mode == `DM_EDIT) |-> key_ok || $past(key_ok))
		else $error("edit mode entered without function key held");
	col_step_a: assert property (cur_col != $past(cur_col) |->
		cur_col == $past(cur_col) + 3'h1 || cur_col == $past(cur_col) - 3'h1)
		else $error("column moved by more than one");
	idle_meter_a: assert property (idle_reg == IDLE_LIM |-> disp_mode == `DM_METER || disp_blank)
		else $error("display not back at meter after idle time");
	event_code_a: assert property (event_stb |-> event_code != 2'h0 ##1 !event_stb)
		else $error("bad archive event strobe");
	ind_blink_a: assert property (input_ind |-> digit_blink || $past(digit_blink))
		else $error("input indicator not blinking");
	digit_room_a: assert property (disp_mode == `DM_EDIT |->
		edit_cursor < edit_ndig && edit_ndig <= 4'h8)
		else $error("cursor outside shown digits");
	msg_after_a: assert property ($rose(disp_mode == `DM_GOOD || disp_mode == `DM_RANGE) |->
		$past(disp_mode) == `DM_EDIT)
		else $error("check message without a confirmed edit");
endmodule // keypad_editor_sva

bind keypad_editor keypad_editor_sva #(.TICK_CYC(TICK_CYC), .DEB_TK(DEB_TK), .MIN_TK(MIN_TK)) sva (
	.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.key_up(key_up), .key_down(key_down), .key_left(key_left), .key_right(key_right),
	.key_ok(key_ok), .cal_button(cal_button), .disp_mode(disp_mode), .disp_blank(disp_blank),
	.cur_col(cur_col), .edit_cursor(edit_cursor), .edit_ndig(edit_ndig),
	.digit_blink(digit_blink), .input_ind(input_ind), .event_stb(event_stb),
	.event_code(event_code));

/* testbench/keypad_editor_bench.sv */
/*
 * Self-checking bench: Wishbone register access, keypad operation through
 * the operator model, editing, access gating, calibration and timeout.
 * Assumes shortened timing: 10 clocks a tick, 100 ticks a minute.
 */
`timescale 1ns/10ps
`include "keypad_editor_defines.vh"

module keypad_editor_bench;
	localparam TK = 10;
	localparam MIN = 100;
	localparam SHORT = 60;
	localparam LONG = 250;
	reg clk, rstn, cyc, stb, we, go;
	reg [7:0] adr;
	reg [3:0] sel;
	reg [31:0] dat, q;
	reg [2:0] ksel;
	reg [15:0] hold;
	reg [1:0] last_ev;
	wire wb_ack_o, key_up, key_down, key_left, key_right, key_ok, cal_button, busy;
	wire disp_blank, digit_blink, input_ind, batt_warn, event_stb;
	wire [31:0] wb_dat_o, edit_digits;
	wire [2:0] disp_mode, cur_col, cur_row, edit_cursor, edit_dp;
	wire [3:0] edit_ndig;
	wire [1:0] event_code;
	integer failures, compares, i, n;

	keypad_editor #(.TICK_CYC(TK), .DEB_TK(2), .LONG_TK(20), .MIN_TK(MIN), .MSG_TK(10),
		.BLINK_TK(5), .HOUR_TK(200)) dut (
		.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.key_up(key_up), .key_down(key_down), .key_left(key_left), .key_right(key_right),
		.key_ok(key_ok), .cal_button(cal_button), .disp_mode(disp_mode), .disp_blank(disp_blank),
		.cur_col(cur_col), .cur_row(cur_row), .edit_digits(edit_digits),
		.edit_cursor(edit_cursor), .edit_dp(edit_dp), .edit_ndig(edit_ndig),
		.digit_blink(digit_blink), .input_ind(input_ind), .batt_warn(batt_warn),
		.event_stb(event_stb), .event_code(event_code));

	keypad_operator #(.GAP(SHORT)) op (.clk(clk), .rstn(rstn), .go(go), .key_sel(ksel),
		.hold_cyc(hold), .key_up(key_up), .key_down(key_down), .key_left(key_left),
		.key_right(key_right), .key_ok(key_ok), .cal_button(cal_button), .busy(busy));

	// ****************************************
	// Tasks
	// ****************************************
	task report_and_stop;
		begin
			$display("compares=%0d failures=%0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Read data and ack are taken at the edge where ack is sampled high.
	task wb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
			n = 0;
			@(posedge clk);
			while (wb_ack_o !== 1'b1 && n < 50) begin
				n = n + 1;
				@(posedge clk);
			end
			q = wb_dat_o;
			cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
			if (n >= 50) begin
				failures = failures + 1;
				report_and_stop;
			end
		end
	endtask

	task rd(input [7:0] a, input [31:0] v);
		begin
			wb(1'b0, a, 32'h0);
			chk(q, v);
		end
	endtask

	task press(input [2:0] k, input [15:0] h);
		begin
			@(posedge clk);
			ksel <= k; hold <= h; go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			n = 0;
			@(posedge clk);
			while (busy !== 1'b0 && n < 2000) begin
				n = n + 1;
				@(posedge clk);
			end
			if (n >= 2000) begin
				failures = failures + 1;
				report_and_stop;
			end
		end
	endtask

	task edit_up(input integer ups, input [3:0] dig, input [2:0] mode, input [31:0] v);
		begin
			press(3'h4, LONG);
			chk(disp_mode, `DM_EDIT);
			repeat (ups) press(3'h0, SHORT);
			chk(edit_digits[3:0], dig);
			press(3'h4, SHORT);
			chk(disp_mode, mode);
			rd(`OFS_VAL_DATA, v);
			repeat (15 * TK) @(posedge clk);
		end
	endtask

	always @(posedge clk)
		if (event_stb === 1'b1)
			last_ev <= event_code;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; go = 1'b0; adr = 8'h00;
		sel = 4'h0; dat = 32'h0; ksel = 3'h0; hold = 16'h0;
		failures = 0; compares = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(`OFS_CTRL, 32'h0);
		rd(`OFS_BATT_CAP, 32'h64);
		rd(8'hfc, 32'h0);
		wb(1'b1, `OFS_CTRL, 32'h3);
		rd(`OFS_CTRL, 32'h3);
		$display("test registers done");
		wb(1'b1, `OFS_BATT_CAP, 32'h9);
		repeat (3) @(posedge clk);
		chk(batt_warn, 1'b1);
		wb(1'b1, `OFS_BATT_CAP, 32'ha);
		repeat (3) @(posedge clk);
		chk(batt_warn, 1'b0);
		$display("test battery done");
		wb(1'b1, `OFS_ACC_WR, {18'h0, 6'h20, 6'h0, `ACC_N});
		wb(1'b1, `OFS_ACC_WR, {18'h0, 6'h00, 6'h0, `ACC_A});
		wb(1'b1, `OFS_VAL_SEL, 32'h20);
		wb(1'b1, `OFS_VAL_DATA, 32'h0);
		for (i = 1; i <= 4; i = i + 1) begin
			press(3'h3, SHORT);
			chk(cur_col, i);
		end
		press(3'h1, SHORT); chk(cur_row, 3'h1);
		press(3'h0, SHORT); chk(cur_row, 3'h0);
		$display("test navigation done");
		for (i = 1; i <= 4; i = i + 1)
			edit_up(1, i[3:0], `DM_GOOD, i);
		edit_up(1, 4'h5, `DM_RANGE, 32'h4);
		$display("test editing done");
		press(3'h4, LONG);
		repeat (5) press(3'h1, SHORT);
		chk(edit_digits[3:0], 4'hf);
		press(3'h2, SHORT);
		chk(edit_cursor, 3'h1);
		chk(edit_ndig, 4'h2);
		press(3'h3, LONG);
		chk(edit_dp, 3'h1);
		press(3'h2, LONG);
		chk(disp_mode, `DM_VALUE);
		rd(`OFS_VAL_DATA, 32'h4);
		$display("test digits done");
		repeat (4) press(3'h2, SHORT);
		chk(cur_col, 3'h0);
		press(3'h4, LONG);
		chk(disp_mode === `DM_EDIT, 1'b0);
		$display("test access done");
		press(3'h5, SHORT);
		chk(last_ev, `EV_CAL_OPEN);
		n = 0;
		while (input_ind !== 1'b1 && n < 200) begin
			n = n + 1;
			@(posedge clk);
		end
		chk(input_ind, 1'b1);
		press(3'h5, SHORT);
		wb(1'b0, `OFS_STATUS, 32'h0); chk(q[3], 1'b0);
		$display("test calibration done");
		wb(1'b1, `OFS_DATE_NOW, 32'h1234);
		wb(1'b1, `OFS_ACC_WR, {18'h0, 6'h2d, 6'h0, `ACC_N});
		for (i = 0; i < 10; i = i + 1)
			press(i < 5 ? 3'h3 : 3'h1, SHORT);
		press(3'h4, LONG);
		press(3'h4, SHORT);
		rd(`OFS_BCHG_DATE, 32'h1234);
		rd(`OFS_OP_HOURS, 32'h0);
		rd(`OFS_BATT_CAP, 32'h64);
		rd(`OFS_EVENT_CNT, 32'h1);
		$display("test battery change done");
		press(3'h1, SHORT);
		chk(disp_mode, `DM_VALUE);
		repeat ((MIN + 10) * TK) @(posedge clk);
		chk(disp_mode, `DM_METER);
		repeat (MIN * TK) @(posedge clk);
		chk(disp_blank, 1'b1);
		press(3'h0, SHORT);
		chk({disp_blank, disp_mode}, {1'b0, `DM_VALUE});
		$display("test timeout done");
		report_and_stop;
	end
endmodule // keypad_editor_bench
